/* File: src/pmr_top.sv */
// two-wire slave register bank of a current and power monitor
// assumes: scl/sda/address pins asynchronous; meas on ref_clk
//
// Behaviour
// - recognise HS code 00001XXX, no ack, fast filters
// - after repeated start, normal protocol at high speed
// - stop leaves HS mode, filters back to normal
// - bit 15 and general call reset equal power-up
// - register contents update 4 us after write
// - pointer 00 is configuration, resets to 399F
// - pointers 01, 02 read shunt and bus results
// - power, current read zero until calibration set
// - pointer 05 is calibration, read/write, resets zero
// - each register moves as two bytes, MSB first
// - bit 15 one resets all, then self-clears
// - bit 13 selects 16 V or 32 V range
// - bits 12:11 select shunt gain, default /8
// - bits 10:7 set bus resolution or averaging
// - bits 6:3 set shunt resolution or averaging
// - bits 2:0 select mode, default continuous both
// - pointer held until a pointer write, bit 15 or general call reset changes it
`timescale 1ns/1ns
`include "pmr_cfg.svh"

module pmr_top
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // two-wire bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // slave address strap
   input wire logic [6:0] dev_addr,
   // measurement results
   input wire pmr_pkg::pmr_meas_type meas,
   // settings to the converter
   output pmr_pkg::pmr_cfg_type cfg_out,
   output logic [15:0] calib_out,
   output logic hs_mode,
   output logic soft_rst_pulse
);
   import pmr_pkg::*;

   // -----------------------------------------------------------
   // pin synchronisers and bus events
   // -----------------------------------------------------------
   logic [`PMR_SYNC_W-1:0] pins_s;
   logic scl_s;
   logic sda_s;
   logic [6:0] addr_s;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic gc_fire;
   logic wr_stb;
   logic [7:0] wr_ptr;
   logic [15:0] wr_data;
   logic [15:0] rd_word;
   logic [7:0] tx_byte;
   pmr_main_type st_reg;
   pmr_main_type st_next;

   pmr_sync pmr_sync_inst
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .raw_in({dev_addr, sda_in, scl_in}),
      .sync_out(pins_s)
   );

   assign scl_s = pins_s[0];
   assign sda_s = pins_s[1];
   assign addr_s = pins_s[8:2];
   assign scl_rise = scl_s & ~st_reg.scl_q;
   assign scl_fall = ~scl_s & st_reg.scl_q;
   assign start_det = scl_s & st_reg.scl_q & st_reg.sda_q & ~sda_s;
   assign stop_det = scl_s & st_reg.scl_q & ~st_reg.sda_q & sda_s;
   assign gc_fire = (st_reg.state == S_RX_ACK) & scl_fall & st_reg.gc_rst;

   // -----------------------------------------------------------
   // delayed register update
   // -----------------------------------------------------------
   pmr_wdelay pmr_wdelay_inst
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .req(st_reg.req),
      .req_ptr(st_reg.ptr),
      .req_data(st_reg.req_data),
      .wr_stb(wr_stb),
      .wr_ptr(wr_ptr),
      .wr_data(wr_data)
   );

   // -----------------------------------------------------------
   // read multiplexer
   // -----------------------------------------------------------
   always_comb
   begin
      case (st_reg.ptr)
         `PMR_PTR_CFG: rd_word = st_reg.cfg;
         `PMR_PTR_SHUNT: rd_word = meas.shunt_volt;
         `PMR_PTR_BUS: rd_word = meas.bus_volt;
         `PMR_PTR_POWER: rd_word = (st_reg.cal != `PMR_ZERO16) ? meas.power : `PMR_ZERO16;
         `PMR_PTR_CURRENT: rd_word = (st_reg.cal != `PMR_ZERO16) ? meas.current : `PMR_ZERO16;
         `PMR_PTR_CAL: rd_word = st_reg.cal;
         default: rd_word = `PMR_ZERO16;
      endcase
      tx_byte = st_reg.lo_next ? rd_word[7:0] : rd_word[15:8];
   end

   // -----------------------------------------------------------
   // slave state machine
   // -----------------------------------------------------------
   always_comb
   begin
      st_next = st_reg;
      st_next.scl_q = scl_s;
      st_next.sda_q = sda_s;
      st_next.req = 1'b0;
      st_next.soft_rst = 1'b0;
      if (start_det)
      begin
         st_next.state = S_ADDR;
         st_next.bit_cnt = '0;
         st_next.sda_oe_n = 1'b1;
      end
      else if (stop_det)
      begin
         st_next.state = S_IDLE;
         st_next.hs_mode = 1'b0;
         st_next.sda_oe_n = 1'b1;
      end
      else
      begin
         case (st_reg.state)
            S_ADDR:
            begin
               if (scl_rise)
               begin
                  st_next.sh = {st_reg.sh[6:0], sda_s};
                  st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
               end
               else if (scl_fall && st_reg.bit_cnt == `PMR_BYTE_BITS)
               begin
                  if (st_reg.sh[7:3] == `PMR_HS_CODE)
                  begin
                     st_next.hs_mode = 1'b1;
                     st_next.state = S_WAIT;
                  end
                  else if (st_reg.sh[7:1] == addr_s)
                  begin
                     st_next.rw = st_reg.sh[0];
                     st_next.gc = 1'b0;
                     st_next.sda_oe_n = 1'b0;
                     st_next.state = S_ADR_ACK;
                  end
                  else if (st_reg.sh == `PMR_GC_ADDR)
                  begin
                     st_next.rw = 1'b0;
                     st_next.gc = 1'b1;
                     st_next.sda_oe_n = 1'b0;
                     st_next.state = S_ADR_ACK;
                  end
                  else
                  begin
                     st_next.state = S_WAIT;
                  end
               end
            end
            S_ADR_ACK:
            begin
               if (scl_fall)
               begin
                  st_next.bit_cnt = '0;
                  st_next.ptr_done = 1'b0;
                  st_next.msb_have = 1'b0;
                  st_next.gc_rst = 1'b0;
                  if (st_reg.rw)
                  begin
                     st_next.sh = rd_word[15:8];
                     st_next.lo_next = 1'b1;
                     st_next.sda_oe_n = rd_word[15];
                     st_next.state = S_TX;
                  end
                  else
                  begin
                     st_next.sda_oe_n = 1'b1;
                     st_next.state = S_RX;
                  end
               end
            end
            S_RX:
            begin
               if (scl_rise)
               begin
                  st_next.sh = {st_reg.sh[6:0], sda_s};
                  st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
               end
               else if (scl_fall && st_reg.bit_cnt == `PMR_BYTE_BITS)
               begin
                  st_next.sda_oe_n = 1'b0;
                  st_next.state = S_RX_ACK;
                  if (st_reg.gc)
                  begin
                     st_next.gc_rst = (st_reg.sh == `PMR_GC_RESET);
                  end
                  else if (!st_reg.ptr_done)
                  begin
                     st_next.ptr = st_reg.sh;
                     st_next.ptr_done = 1'b1;
                  end
                  else if (!st_reg.msb_have)
                  begin
                     st_next.msb = st_reg.sh;
                     st_next.msb_have = 1'b1;
                  end
                  else
                  begin
                     st_next.req = 1'b1;
                     st_next.req_data = {st_reg.msb, st_reg.sh};
                     st_next.msb_have = 1'b0;
                  end
               end
            end
            S_RX_ACK:
            begin
               if (scl_fall)
               begin
                  st_next.sda_oe_n = 1'b1;
                  st_next.bit_cnt = '0;
                  st_next.state = S_RX;
                  if (st_reg.gc_rst)
                  begin
                     st_next.gc_rst = 1'b0;
                     st_next.cfg = `PMR_CFG_RST;
                     st_next.cal = `PMR_ZERO16;
                     st_next.ptr = `PMR_PTR_CFG;
                     st_next.hs_mode = 1'b0;
                     st_next.soft_rst = 1'b1;
                  end
               end
            end
            S_TX:
            begin
               if (scl_rise)
               begin
                  st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
               end
               else if (scl_fall)
               begin
                  if (st_reg.bit_cnt == `PMR_BYTE_BITS)
                  begin
                     st_next.sda_oe_n = 1'b1;
                     st_next.state = S_TX_ACK;
                  end
                  else
                  begin
                     st_next.sh = {st_reg.sh[6:0], 1'b0};
                     st_next.sda_oe_n = st_reg.sh[6];
                  end
               end
            end
            S_TX_ACK:
            begin
               if (scl_rise)
               begin
                  st_next.mack = ~sda_s;
               end
               else if (scl_fall)
               begin
                  if (st_reg.mack)
                  begin
                     st_next.sh = tx_byte;
                     st_next.sda_oe_n = tx_byte[7];
                     st_next.lo_next = ~st_reg.lo_next;
                     st_next.bit_cnt = '0;
                     st_next.state = S_TX;
                  end
                  else
                  begin
                     st_next.state = S_WAIT;
                  end
               end
            end
            S_WAIT, S_IDLE:
            begin
               st_next.sda_oe_n = 1'b1;
            end
            default:
            begin
               st_next.state = S_IDLE;
               st_next.sda_oe_n = 1'b1;
            end
         endcase
      end
      // delayed write reaches the registers
      if (wr_stb)
      begin
         case (wr_ptr)
            `PMR_PTR_CFG:
            begin
               if (wr_data[`PMR_SOFT_RST_BIT])
               begin
                  st_next.cfg = `PMR_CFG_RST;
                  st_next.cal = `PMR_ZERO16;
                  st_next.ptr = `PMR_PTR_CFG;
                  st_next.hs_mode = 1'b0;
                  st_next.soft_rst = 1'b1;
               end
               else
               begin
                  st_next.cfg = wr_data;
               end
            end
            `PMR_PTR_CAL: st_next.cal = wr_data;
            default: st_next.cal = st_next.cal;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         st_reg <= '0;
         st_reg.scl_q <= 1'b1;
         st_reg.sda_q <= 1'b1;
         st_reg.sda_oe_n <= 1'b1;
         st_reg.cfg <= `PMR_CFG_RST;
         st_reg.hs_mode <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // -----------------------------------------------------------
   // outputs
   // -----------------------------------------------------------
   assign sda_out = st_reg.sda_o;
   assign sda_oe_n = st_reg.sda_oe_n;
   assign cfg_out = st_reg.cfg;
   assign calib_out = st_reg.cal;
   assign hs_mode = st_reg.hs_mode;
   assign soft_rst_pulse = st_reg.soft_rst;

   // -----------------------------------------------------------
   // checks
   // -----------------------------------------------------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   hs_code_a:
   assert property (st_reg.state == S_ADDR && scl_fall && !start_det && !stop_det
      && st_reg.bit_cnt == `PMR_BYTE_BITS && st_reg.sh[7:3] == `PMR_HS_CODE && !wr_stb
      |=> hs_mode && sda_oe_n && st_reg.state == S_WAIT)
      else $error("hs code not taken silently");

   stop_exit_a:
   assert property (stop_det && !start_det |=> !hs_mode && st_reg.state == S_IDLE)
      else $error("stop did not leave hs mode");

   ptr_hold_a:
   assert property (!(st_reg.state == S_RX && scl_fall) && !gc_fire && !wr_stb
      |=> $stable(st_reg.ptr))
      else $error("pointer changed without a write");

   gate_zero_a:
   assert property (st_reg.cal == `PMR_ZERO16
      && (st_reg.ptr == `PMR_PTR_POWER || st_reg.ptr == `PMR_PTR_CURRENT)
      |-> rd_word == `PMR_ZERO16)
      else $error("power or current nonzero without calibration");

   cal_write_a:
   assert property (wr_stb && wr_ptr == `PMR_PTR_CAL |=> calib_out == $past(wr_data))
      else $error("calibration write lost");

   soft_rst_a:
   assert property (wr_stb && wr_ptr == `PMR_PTR_CFG && wr_data[`PMR_SOFT_RST_BIT]
      |=> (cfg_out == `PMR_CFG_RST && calib_out == `PMR_ZERO16 && soft_rst_pulse)
      ##1 !soft_rst_pulse)
      else $error("soft reset did not restore defaults");

   bit14_keep_a:
   assert property (wr_stb && wr_ptr == `PMR_PTR_CFG && !wr_data[`PMR_SOFT_RST_BIT]
      |=> cfg_out == $past(wr_data) && !cfg_out.soft_reset_bit)
      else $error("configuration write not stored");

   ro_keep_a:
   assert property (wr_stb && wr_ptr != `PMR_PTR_CFG && wr_ptr != `PMR_PTR_CAL && !gc_fire
      |=> $stable(cfg_out) && $stable(calib_out))
      else $error("read-only write changed a register");

   tx_msb_a:
   assert property (st_reg.state == S_ADR_ACK && scl_fall && st_reg.rw
      && !start_det && !stop_det
      |=> st_reg.sh == $past(rd_word[15:8]) && st_reg.state == S_TX)
      else $error("read did not start with high byte");

endmodule // pmr_top

/* File: src/pmr_cfg.svh */
// constants of the power monitor register bank
// assumes: included by package and modules by its bare name
`ifndef PMR_CFG_SVH
`define PMR_CFG_SVH

// --------------------------------------------------------------
// register pointers
// --------------------------------------------------------------
`define PMR_PTR_CFG 8'h00
`define PMR_PTR_SHUNT 8'h01
`define PMR_PTR_BUS 8'h02
`define PMR_PTR_POWER 8'h03
`define PMR_PTR_CURRENT 8'h04
`define PMR_PTR_CAL 8'h05

// --------------------------------------------------------------
// reset values and field positions
// --------------------------------------------------------------
`define PMR_CFG_RST 16'h399f
`define PMR_ZERO16 16'h0000
`define PMR_SOFT_RST_BIT 15
`define PMR_SYNC_W 9
`define PMR_SYNC_RST 9'h1ff

// --------------------------------------------------------------
// two-wire protocol
// --------------------------------------------------------------
`define PMR_HS_CODE 5'h01
`define PMR_GC_ADDR 8'h00
`define PMR_GC_RESET 8'h06
`define PMR_BYTE_BITS 4'h8

// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define PMR_REF_PERIOD_NS 100
`define PMR_WR_DLY_NS 4000
`define PMR_WR_DLY_CYC ((`PMR_WR_DLY_NS + `PMR_REF_PERIOD_NS - 1) / `PMR_REF_PERIOD_NS)
`define PMR_CNT_W 6

`endif

/* File: src/pmr_pkg.sv */
// types of the power monitor register bank
// assumes: pmr_cfg.svh on the include path
`include "pmr_cfg.svh"

package pmr_pkg;

   // -----------------------------------------------------------
   // register fields and measurement inputs
   // -----------------------------------------------------------
   typedef struct packed {
      logic soft_reset_bit;
      logic spare_bit;
      logic bus_range_select;
      logic [1:0] shunt_gain_select;
      logic [3:0] bus_conv_setting;
      logic [3:0] shunt_conv_setting;
      logic [2:0] op_mode;
   } pmr_cfg_type;

   typedef struct packed {
      logic [15:0] shunt_volt;
      logic [15:0] bus_volt;
      logic [15:0] power;
      logic [15:0] current;
   } pmr_meas_type;

   // -----------------------------------------------------------
   // module state
   // -----------------------------------------------------------
   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_ADDR = 3'h1,
      S_ADR_ACK = 3'h3,
      S_RX = 3'h2,
      S_RX_ACK = 3'h6,
      S_TX = 3'h7,
      S_TX_ACK = 3'h5,
      S_WAIT = 3'h4
   } pmr_fsm_type;

   typedef struct packed {
      pmr_fsm_type state;
      logic scl_q;
      logic sda_q;
      logic [3:0] bit_cnt;
      logic [7:0] sh;
      logic rw;
      logic gc;
      logic gc_rst;
      logic mack;
      logic lo_next;
      logic ptr_done;
      logic msb_have;
      logic [7:0] msb;
      logic [7:0] ptr;
      logic hs_mode;
      pmr_cfg_type cfg;
      logic [15:0] cal;
      logic sda_oe_n;
      logic sda_o;
      logic req;
      logic [15:0] req_data;
      logic soft_rst;
   } pmr_main_type;

   typedef struct packed {
      logic busy;
      logic [`PMR_CNT_W-1:0] cnt;
      logic stb;
      logic [7:0] ptr;
      logic [15:0] data;
   } pmr_wd_type;

   typedef struct packed {
      logic [`PMR_SYNC_W-1:0] meta;
      logic [`PMR_SYNC_W-1:0] sync;
   } pmr_sync_type;

endpackage

/* File: src/pmr_sync.sv */
// two-flop synchroniser for the bus pins and address strap
// assumes: raw inputs are asynchronous to ref_clk
`timescale 1ns/1ns
`include "pmr_cfg.svh"

module pmr_sync
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // pins
   input wire logic [`PMR_SYNC_W-1:0] raw_in,
   output logic [`PMR_SYNC_W-1:0] sync_out
);
   import pmr_pkg::*;

   pmr_sync_type st_reg;
   pmr_sync_type st_next;

   always_comb
   begin
      st_next = st_reg;
      st_next.meta = raw_in;
      st_next.sync = st_reg.meta;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         st_reg.meta <= `PMR_SYNC_RST;
         st_reg.sync <= `PMR_SYNC_RST;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign sync_out = st_reg.sync;

endmodule // pmr_sync

/* File: src/pmr_wdelay.sv */
// delays a register write by the fixed update time
// assumes: req is a one-cycle pulse on ref_clk, never while busy
`timescale 1ns/1ns
`include "pmr_cfg.svh"

module pmr_wdelay
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // write request
   input wire logic req,
   input wire logic [7:0] req_ptr,
   input wire logic [15:0] req_data,
   // delayed write
   output logic wr_stb,
   output logic [7:0] wr_ptr,
   output logic [15:0] wr_data
);
   import pmr_pkg::*;

   localparam int DLY = `PMR_WR_DLY_CYC;
   localparam logic [`PMR_CNT_W-1:0] CNT_LOAD = `PMR_CNT_W'(`PMR_WR_DLY_CYC - 2);

   pmr_wd_type st_reg;
   pmr_wd_type st_next;

   always_comb
   begin
      st_next = st_reg;
      st_next.stb = 1'b0;
      if (st_reg.busy)
      begin
         if (st_reg.cnt == '0)
         begin
            st_next.stb = 1'b1;
            st_next.busy = 1'b0;
         end
         else
         begin
            st_next.cnt = st_reg.cnt - 1'b1;
         end
      end
      else if (req)
      begin
         st_next.busy = 1'b1;
         st_next.cnt = CNT_LOAD;
         st_next.ptr = req_ptr;
         st_next.data = req_data;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign wr_stb = st_reg.stb;
   assign wr_ptr = st_reg.ptr;
   assign wr_data = st_reg.data;

   wr_delay_a:
   assert property (@(posedge ref_clk) disable iff (rst)
      req && !st_reg.busy |-> ##[DLY:DLY] (wr_stb && wr_data == $past(req_data, DLY)))
      else $error("register write not applied after update delay");

endmodule // pmr_wdelay

/* File: tb/pmr_master.sv */
// two-wire bus master model for the register bank bench
// assumes: bench resolves the open-drain data line with a pull-up
`timescale 1ns/1ns

module pmr_master
(
   // bus pins
   output logic scl,
   output logic sda_m,
   input wire logic sda
);
   // quarter bit time in ns; 200 gives the 800 ns link clock
   int q = 200;

   initial
   begin
      scl = 1'b1;
      sda_m = 1'b1;
   end

   // drive b while scl low, sample the resolved line while high
   task automatic bit_x(input logic b, output logic s);
      scl = 1'b0;
      #q sda_m = b;
      #q scl = 1'b1;
      #q s = sda;
      #q;
   endtask

   // start or repeated start; repeats keep high-speed mode
   task automatic start_c;
      scl = 1'b0;
      #q sda_m = 1'b1;
      #q scl = 1'b1;
      #(2*q) sda_m = 1'b0;
      #(2*q);
   endtask

   task automatic stop_c;
      scl = 1'b0;
      #q sda_m = 1'b0;
      #q scl = 1'b1;
      #(2*q) sda_m = 1'b1;
      #(2*q);
   endtask

   // eight bits msb first, then ninth bit m, sampled into a
   task automatic byte_x(input logic [7:0] d, input logic m, output logic [7:0] r,
      output logic a);
      for (int i = 7; i >= 0; i--)
         bit_x(d[i], r[i]);
      bit_x(m, a);
   endtask
endmodule // pmr_master

/* File: tb/power_monitor_register_bank_bench.sv */
// self-checking bench of the power monitor register bank
// assumes: src/ design files and tb/pmr_master.sv compiled first
`timescale 1ns/1ns

module power_monitor_register_bank_bench;
   import pmr_pkg::*;
   typedef struct packed {logic [7:0] ptr; logic wr;
      logic [15:0] wd; logic [15:0] ex;} pmr_row_type;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic scl, sda_m, sda_out, sda_oe_n, hs_mode, soft_rst_pulse, a;
   logic [15:0] calib_out;
   logic [15:0] v;
   logic [7:0] r;
   pmr_cfg_type cfg_out;
   pmr_meas_type meas = {16'h8300, 16'h1f40, 16'h0a5a, 16'h5a0a};
   int n_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   int n_pulse = 0;
   wire sda = sda_m & (sda_oe_n | sda_out);
   pmr_row_type rows [13] = '{
      {8'h00, 1'b0, 16'h0000, 16'h399f}, {8'h05, 1'b0, 16'h0000, 16'h0000},
      {8'h03, 1'b0, 16'h0000, 16'h0000}, {8'h04, 1'b0, 16'h0000, 16'h0000},
      {8'h01, 1'b0, 16'h0000, 16'h8300}, {8'h02, 1'b0, 16'h0000, 16'h1f40},
      {8'h01, 1'b1, 16'h0000, 16'h8300}, {8'h03, 1'b1, 16'h1234, 16'h0000},
      {8'h00, 1'b1, 16'h4123, 16'h4123}, {8'h05, 1'b1, 16'h0001, 16'h0001},
      {8'h03, 1'b0, 16'h0000, 16'h0a5a}, {8'h04, 1'b0, 16'h0000, 16'h5a0a},
      {8'h07, 1'b0, 16'h0000, 16'h0000}};

   pmr_master pmr_master_inst (.scl(scl), .sda_m(sda_m), .sda(sda));
   pmr_top pmr_top_inst (.ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .dev_addr(7'h45), .meas(meas),
      .cfg_out(cfg_out), .calib_out(calib_out), .hs_mode(hs_mode),
      .soft_rst_pulse(soft_rst_pulse));

   always #50 ref_clk = ~ref_clk;

   always @(negedge ref_clk)
   begin
      cycles++;
      n_pulse += (soft_rst_pulse === 1'b1);
      if (cycles == 30000)
      begin
         n_errors++;
         complete_run();
      end
   end

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wb(input logic [7:0] d);
      pmr_master_inst.byte_x(d, 1'b1, r, a);
      chk("ack", 16'h0000, {15'h0000, a});
   endtask

   // pointer, then both data bytes msb first when two is set
   task automatic wr(input logic [7:0] p, input logic [15:0] d, input logic two);
      pmr_master_inst.start_c();
      wb(8'h8a);
      wb(p);
      if (two)
      begin
         wb(d[15:8]);
         wb(d[7:0]);
      end
   endtask

   task automatic rd(output logic [15:0] d);
      pmr_master_inst.start_c();
      wb(8'h8b);
      pmr_master_inst.byte_x(8'hff, 1'b0, d[15:8], a);
      pmr_master_inst.byte_x(8'hff, 1'b1, d[7:0], a);
      pmr_master_inst.stop_c();
   endtask

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (10) @(negedge ref_clk);
      rst = 1'b0;
      foreach (rows[i])
      begin
         wr(rows[i].ptr, rows[i].wd, rows[i].wr);
         #5000;
         rd(v);
         chk("row", rows[i].ex, v);
      end
      $display("test rows done");
      wr(8'h00, 16'h0000, 1'b1);
      chk("cfg early", 16'h4123, cfg_out);
      #3200;
      chk("cfg mid", 16'h4123, cfg_out);
      #800;
      chk("cfg late", 16'h0000, cfg_out);
      $display("test update delay done");
      pmr_master_inst.stop_c();
      wr(8'h00, 16'h8000, 1'b1);
      pmr_master_inst.stop_c();
      #5000;
      rd(v);
      chk("soft cfg", 16'h399f, v);
      chk("soft cal", 16'h0000, calib_out);
      chk("soft pulse", 16'h0001, n_pulse[15:0]);
      $display("test soft reset done");
      wr(8'h05, 16'h00aa, 1'b1);
      #5000;
      chk("cal", 16'h00aa, calib_out);
      pmr_master_inst.start_c();
      wb(8'h00);
      wb(8'h06);
      pmr_master_inst.stop_c();
      chk("gc cal", 16'h0000, calib_out);
      $display("test general call done");
      wr(8'h02, 16'h0000, 1'b0);
      pmr_master_inst.q = 700;
      pmr_master_inst.start_c();
      pmr_master_inst.byte_x(8'h09, 1'b1, r, a);
      pmr_master_inst.q = 200;
      chk("hs nack", 16'h0001, {15'h0000, a});
      chk("hs on", 16'h0001, {15'h0000, hs_mode});
      wr(8'h02, 16'h0000, 1'b0);
      chk("hs kept", 16'h0001, {15'h0000, hs_mode});
      rd(v);
      chk("hs read", 16'h1f40, v);
      #200;
      chk("hs off", 16'h0000, {15'h0000, hs_mode});
      rd(v);
      chk("ptr held", 16'h1f40, v);
      $display("test high speed done");
      wr(8'h05, 16'h0033, 1'b1);
      #5000;
      chk("cal set", 16'h0033, calib_out);
      pmr_master_inst.q = 700;
      pmr_master_inst.start_c();
      pmr_master_inst.byte_x(8'h09, 1'b1, r, a);
      pmr_master_inst.q = 200;
      chk("hs again", 16'h0001, {15'h0000, hs_mode});
      @(negedge ref_clk);
      rst = 1'b1;
      @(negedge ref_clk);
      chk("rst hs", 16'h0000, {15'h0000, hs_mode});
      chk("rst cal", 16'h0000, calib_out);
      repeat (10) @(negedge ref_clk);
      rst = 1'b0;
      pmr_master_inst.stop_c();
      $display("test reset done");
      complete_run();
   end
endmodule // power_monitor_register_bank_bench
